// ### tmcf_regs.vh
// Purpose: Constants for the test-mode contact forcing block
// Assumes: APB slave, 32-bit data, 200 MHz clock
// Notes:   Offsets are byte addresses
`ifndef TMCF_REGS_VH
`define TMCF_REGS_VH

`define TMCF_NIN          8
`define TMCF_NOUT         8
`define TMCF_ADDR_W       12

`define TMCF_OFF_CTRL     12'h000
`define TMCF_OFF_INFRC    12'h004
`define TMCF_OFF_OUTFRC   12'h008
`define TMCF_OFF_STATUS   12'h00C
`define TMCF_OFF_INSTATE  12'h010
`define TMCF_OFF_OUTSTATE 12'h014

// Control fields
`define TMCF_CTRL_EN      0
`define TMCF_CTRL_SRC     1

// Status fields
`define TMCF_ST_ACTIVE    0
`define TMCF_ST_LED       1

// Input forcing codes, two bits per channel
`define TMCF_IN_DIS       2'h0
`define TMCF_IN_OPEN      2'h1
`define TMCF_IN_CLOSED    2'h2

// Output forcing codes, two bits per channel
`define TMCF_OUT_DIS      2'h0
`define TMCF_OUT_ENERG    2'h1
`define TMCF_OUT_DEENERG  2'h2
`define TMCF_OUT_FREEZE   2'h3

// Flash half period
`define TMCF_FLASH_MS     250
`define TMCF_CLK_MHZ      200
`define TMCF_FLASH_CYC    (`TMCF_FLASH_MS * 1000 * `TMCF_CLK_MHZ)
`define TMCF_FLASH_W      26

`endif

// ### tmcf_test_mode.v
// Purpose: Test-mode entry, indicator flashing and contact forcing
// Assumes: Contact and trigger inputs are asynchronous to clk
// Notes:   Operand outputs pass unchanged outside of test mode;
//          read data is loaded in the setup cycle, so it stands
//          while pready is high in the access cycle
//
// Overview of operation
// - Test mode is active only while enabled and the trigger is 1.
// - With a fixed On trigger, test mode starts when enable goes high.
// - With an operand trigger and enable set, test mode starts on 1.
// - While test mode is active the test indicator flashes.
// - Only contact inputs and outputs are touched by test mode.
// - Each contact input and output has its own forcing selection.
// - An input set to disabled reports its sensed terminal state.
// - An input set to open reports 0 throughout test mode.
// - An input set to closed reports 1 throughout test mode.
// - Each output follows open, closed, freeze or normal selection.
// - With all input selections disabled, inputs report normally.
// - A frozen output keeps its pre-test position until test ends.
// - Energize closes and de-energize opens an output in test mode.
`timescale 1ns/1ps
`include "tmcf_regs.vh"

module tmcf_test_mode #(
   parameter FLASH_CYC = `TMCF_FLASH_CYC
) (
   input  wire                      clk,
   input  wire                      rst,
   input  wire                      ce,
   input  wire                      psel,
   input  wire                      penable,
   input  wire                      pwrite,
   input  wire [`TMCF_ADDR_W-1:0]   paddr,
   input  wire [31:0]               pwdata,
   output reg  [31:0]               prdata,
   output wire                      pready,
   output wire                      pslverr,
   input  wire                      triggerOperand,
   input  wire [`TMCF_NIN-1:0]      contactIn,
   input  wire [`TMCF_NOUT-1:0]     outOperand,
   output reg  [`TMCF_NIN-1:0]      inReport,
   output reg  [`TMCF_NOUT-1:0]     contactDrive,
   output reg                       testLed,
   output wire                      testActive
);

   //////////////////////////////////////////////////////////////////////
   // Registers
   reg                        enable_reg;
   reg                        srcOperand_reg;
   reg  [2*`TMCF_NIN-1:0]     inForce_reg;
   reg  [2*`TMCF_NOUT-1:0]    outForce_reg;
   reg                        active_reg;
   reg  [`TMCF_NOUT-1:0]      frozen_reg;
   reg  [`TMCF_FLASH_W-1:0]   flashCnt_reg;
   wire [`TMCF_NIN-1:0]       inSync;
   wire                       trigSync;
   wire [`TMCF_NIN-1:0]       inNext;
   wire [`TMCF_NOUT-1:0]      driveNext;
   wire                       trigger;
   wire                       activeNext;
   wire                       wrEn;
   wire                       rdEn;
   genvar                     g;

   //////////////////////////////////////////////////////////////////////
   // Synchronisers for pin inputs
   // Two flops stop metastability only; contact bounce is not filtered
   tmcf_sync2 #(
      .W (`TMCF_NIN)
   ) i_tmcf_sync2_in (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .d   (contactIn),
      .q   (inSync)
   );

   tmcf_sync2 #(
      .W (1)
   ) i_tmcf_sync2_trig (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .d   (triggerOperand),
      .q   (trigSync)
   );

   //////////////////////////////////////////////////////////////////////
   // Test mode qualification
   // Fixed On trigger means entry follows the enable edge itself
   assign trigger    = srcOperand_reg ? trigSync : 1'b1;
   assign activeNext = enable_reg & trigger;
   assign testActive = active_reg;

   //////////////////////////////////////////////////////////////////////
   // APB slave, zero wait states
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign wrEn    = psel & penable & pwrite;
   // Reads load in setup so data stands when pready is sampled
   assign rdEn    = psel & ~penable & ~pwrite;

   always @(posedge clk) begin
      if (rst) begin
         enable_reg     <= 1'b0;
         srcOperand_reg <= 1'b0;
         inForce_reg    <= {2*`TMCF_NIN{1'b0}};
         outForce_reg   <= {2*`TMCF_NOUT{1'b0}};
         prdata         <= 32'h00000000;
      end else if (ce) begin
         if (wrEn) begin
            case (paddr)
               `TMCF_OFF_CTRL: begin
                  enable_reg     <= pwdata[`TMCF_CTRL_EN];
                  srcOperand_reg <= pwdata[`TMCF_CTRL_SRC];
               end
               `TMCF_OFF_INFRC:  inForce_reg  <= pwdata[2*`TMCF_NIN-1:0];
               `TMCF_OFF_OUTFRC: outForce_reg <= pwdata[2*`TMCF_NOUT-1:0];
               default: ;
            endcase
         end
         if (rdEn) begin
            prdata <= 32'h00000000;
            case (paddr)
               `TMCF_OFF_CTRL: begin
                  prdata[`TMCF_CTRL_EN]  <= enable_reg;
                  prdata[`TMCF_CTRL_SRC] <= srcOperand_reg;
               end
               `TMCF_OFF_INFRC:  prdata[2*`TMCF_NIN-1:0]  <= inForce_reg;
               `TMCF_OFF_OUTFRC: prdata[2*`TMCF_NOUT-1:0] <= outForce_reg;
               `TMCF_OFF_STATUS: begin
                  prdata[`TMCF_ST_ACTIVE] <= active_reg;
                  prdata[`TMCF_ST_LED]    <= testLed;
               end
               `TMCF_OFF_INSTATE:  prdata[`TMCF_NIN-1:0]  <= inReport;
               `TMCF_OFF_OUTSTATE: prdata[`TMCF_NOUT-1:0] <= contactDrive;
               default: prdata <= 32'h00000000;
            endcase
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Mode state, freeze capture and indicator flashing
   always @(posedge clk) begin
      if (rst) begin
         active_reg   <= 1'b0;
         frozen_reg   <= {`TMCF_NOUT{1'b0}};
         flashCnt_reg <= {`TMCF_FLASH_W{1'b0}};
         testLed      <= 1'b0;
      end else if (ce) begin
         active_reg <= activeNext;
         // Capture on entry so frozen outputs hold the pre-test position
         if (activeNext & ~active_reg)
            frozen_reg <= contactDrive;
         if (active_reg) begin
            if (flashCnt_reg == FLASH_CYC[`TMCF_FLASH_W-1:0] - 1'b1) begin
               flashCnt_reg <= {`TMCF_FLASH_W{1'b0}};
               testLed      <= ~testLed;
            end else begin
               flashCnt_reg <= flashCnt_reg + 1'b1;
            end
         end else begin
            flashCnt_reg <= {`TMCF_FLASH_W{1'b0}};
            testLed      <= 1'b0;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Per-channel forcing; operands of other functions never pass here
   generate
      for (g = 0; g < `TMCF_NIN; g = g + 1) begin : g_in
         tmcf_in_chan i_tmcf_in_chan (
            .active (active_reg),
            .sel    (inForce_reg[2*g +: 2]),
            .sensed (inSync[g]),
            .report (inNext[g])
         );
      end
      for (g = 0; g < `TMCF_NOUT; g = g + 1) begin : g_out
         tmcf_out_chan i_tmcf_out_chan (
            .active  (active_reg),
            .sel     (outForce_reg[2*g +: 2]),
            .operand (outOperand[g]),
            .frozen  (frozen_reg[g]),
            .drive   (driveNext[g])
         );
      end
   endgenerate

   // Registered so the pins never see a glitch while settings change
   always @(posedge clk) begin
      if (rst) begin
         inReport     <= {`TMCF_NIN{1'b0}};
         contactDrive <= {`TMCF_NOUT{1'b0}};
      end else if (ce) begin
         inReport     <= inNext;
         contactDrive <= driveNext;
      end
   end

endmodule // tmcf_test_mode

//////////////////////////////////////////////////////////////////////////
// Two-flop synchroniser; only the second stage is read outside
// Reset clears both stages, so a pin held high shows up two edges late
module tmcf_sync2 #(
   parameter W = 1
) (
   input  wire           clk,
   input  wire           rst,
   input  wire           ce,
   input  wire [W-1:0]   d,
   output wire [W-1:0]   q
);

   reg  [W-1:0]   stage1_reg;
   reg  [W-1:0]   stage2_reg;

   always @(posedge clk) begin
      if (rst) begin
         stage1_reg <= {W{1'b0}};
         stage2_reg <= {W{1'b0}};
      end else if (ce) begin
         stage1_reg <= d;
         stage2_reg <= stage1_reg;
      end
   end

   assign q = stage2_reg;

endmodule // tmcf_sync2

//////////////////////////////////////////////////////////////////////////
// Reported state of one contact input
// Outside test mode the selection is ignored, so settings may be
// prepared in advance without disturbing the reported states
module tmcf_in_chan (
   input  wire         active,
   input  wire [1:0]   sel,
   input  wire         sensed,
   output reg          report
);

   always @* begin
      report = sensed;
      if (active) begin
         case (sel)
            `TMCF_IN_OPEN:   report = 1'b0;
            `TMCF_IN_CLOSED: report = 1'b1;
            // Disabled and the unused code both pass terminal state
            default:         report = sensed;
         endcase
      end
   end

endmodule // tmcf_in_chan

//////////////////////////////////////////////////////////////////////////
// Drive of one contact output
// Freeze uses the position captured at entry, not a live sample,
// so an operand change on the entry edge cannot leak through
module tmcf_out_chan (
   input  wire         active,
   input  wire [1:0]   sel,
   input  wire         operand,
   input  wire         frozen,
   output reg          drive
);

   always @* begin
      drive = operand;
      if (active) begin
         case (sel)
            `TMCF_OUT_ENERG:   drive = 1'b1;
            `TMCF_OUT_DEENERG: drive = 1'b0;
            `TMCF_OUT_FREEZE:  drive = frozen;
            default:           drive = operand;
         endcase
      end
   end

endmodule // tmcf_out_chan

// ### tmcf_test_mode_sva.sv
// Purpose: Port checks for tmcf_test_mode
// Assumes: FLASH_CYC equals the instance value
// Notes:   runCnt skips cycles whose history reset or ce spoils
`timescale 1ns/1ps
`include "tmcf_regs.vh"
module tmcf_test_mode_sva #(
   parameter FLASH_CYC = 4
) (
   input wire                   clk,
   input wire                   rst,
   input wire                   ce,
   input wire                   psel,
   input wire                   penable,
   input wire                   pwrite,
   input wire                   pready,
   input wire                   pslverr,
   input wire                   testLed,
   input wire                   testActive,
   input wire [31:0]            prdata,
   input wire [`TMCF_NIN-1:0]   contactIn,
   input wire [`TMCF_NIN-1:0]   inReport,
   input wire [`TMCF_NOUT-1:0]  outOperand,
   input wire [`TMCF_NOUT-1:0]  contactDrive
);
   localparam int LEDMAX = 2 * FLASH_CYC + 4;
   reg [2:0] runCnt;
   always @(posedge clk)
      runCnt <= (rst || !ce) ? 3'h0 : runCnt + {2'h0, runCnt != 3'h7};
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   a_bus_answer: assert property (pready && !pslverr)
      else $error("bus answer wrong");
   a_read_hold: assert property (!(psel && !penable && !pwrite) |=>
      $stable(prdata)) else $error("read data moved");
   a_reset_clear: assert property ($past(rst) |-> !testActive && !testLed &&
      contactDrive == 0 && inReport == 0) else $error("reset state");
   a_led_idle: assert property (runCnt > 3 && !testActive &&
      !$past(testActive) && !$past(testActive, 2) |-> !testLed)
      else $error("indicator lit outside test");
   a_led_flash: assert property ($rose(testActive) |->
      ##[1:LEDMAX] (testLed || !testActive)) else $error("no flash");
   a_drive_normal: assert property (runCnt > 1 && !testActive &&
      !$past(testActive) |-> contactDrive == $past(outOperand))
      else $error("drive not following operand");
   a_input_normal: assert property (runCnt > 3 && !testActive &&
      !$past(testActive) |-> inReport == $past(contactIn, 3))
      else $error("report not following terminal");
   a_hold_frozen: assert property (!ce |=> $stable({testActive, testLed,
      contactDrive, inReport})) else $error("state moved with ce low");
endmodule // tmcf_test_mode_sva
bind tmcf_test_mode tmcf_test_mode_sva #(.FLASH_CYC(FLASH_CYC)) i_sva (.*);

// ### tmcf_contact_model.sv
// Purpose: Contact circuits and trigger logic beside the block
// Assumes: Bench chooses the levels
// Notes:   Levels land 2 ns after the edge, like unsynchronised wiring
`timescale 1ns/1ps
`include "tmcf_regs.vh"
module tmcf_contact_model (
   input  wire                      clk,
   input  wire [`TMCF_NIN-1:0]      wantIn,
   input  wire                      wantTrig,
   output logic [`TMCF_NIN-1:0]     contactIn = '0,
   output logic                     triggerOperand = 1'b0
);
   always @(posedge clk) begin
      contactIn <= #2 wantIn;
      triggerOperand <= #2 wantTrig;
   end
endmodule // tmcf_contact_model

// ### test_tmcf_test_mode.sv
// Purpose: Self-checking bench for tmcf_test_mode
// Assumes: FLASH_CYC of 4 keeps flashing short
// Notes:   Read data is taken once the access edge has landed
`timescale 1ns/1ps
`include "tmcf_regs.vh"
module test_tmcf_test_mode;
   reg clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, wantTrig = 0;
   reg ce = 1;
   reg [11:0] paddr = 0;
   reg [31:0] pwdata = 0, q;
   reg [7:0] outOperand = 0, wantIn = 0, frz;
   reg [15:0] inFrc, outFrc;
   wire [31:0] prdata;
   wire pready, pslverr, triggerOperand, testLed, testActive;
   wire [7:0] contactIn, inReport, contactDrive;
   integer n_errors = 0, n_compared = 0, seed = 10, i, k;
   tmcf_test_mode #(.FLASH_CYC(4)) i_tmcf_test_mode (.clk(clk), .rst(rst),
      .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .triggerOperand(triggerOperand),
      .contactIn(contactIn), .outOperand(outOperand), .inReport(inReport),
      .contactDrive(contactDrive), .testLed(testLed),
      .testActive(testActive));
   tmcf_contact_model i_tmcf_contact_model (.clk(clk), .wantIn(wantIn),
      .wantTrig(wantTrig), .contactIn(contactIn),
      .triggerOperand(triggerOperand));
   initial forever #2.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task chk(input [31:0] seen, exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task apb(input wr, input [11:0] a, input [31:0] d);
      begin
         psel <= 1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge clk) penable <= 1;
         @(posedge clk);
         while (pready !== 1'b1) @(posedge clk);
         q = prdata;
         psel <= 0;
         penable <= 0;
         @(posedge clk);
      end
   endtask
   task waitAct(input v);
      begin
         repeat (40) if (testActive !== v) @(posedge clk);
         chk(testActive, v);
      end
   endtask
   function [7:0] expIn(input [15:0] f, input [7:0] pin);
      for (k = 0; k < 8; k = k + 1)
         expIn[k] = f[2*k+:2] == `TMCF_IN_OPEN ? 1'b0 :
            f[2*k+:2] == `TMCF_IN_CLOSED ? 1'b1 : pin[k];
   endfunction
   function [7:0] expOut(input [15:0] f, input [7:0] op, fz);
      for (k = 0; k < 8; k = k + 1)
         expOut[k] = f[2*k+:2] == `TMCF_OUT_ENERG ? 1'b1 :
            f[2*k+:2] == `TMCF_OUT_DEENERG ? 1'b0 :
            f[2*k+:2] == `TMCF_OUT_FREEZE ? fz[k] : op[k];
   endfunction
   task final_report;
      begin
         $display("compared %0d errors %0d", n_compared, n_errors);
         if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      n_errors = n_errors + 1;
      final_report;
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      apb(0, `TMCF_OFF_OUTFRC, 0);
      chk(q, 0);
      apb(0, 12'h040, 0);
      chk(q, 0);
      for (i = 0; i < 6; i = i + 1) begin
         inFrc = i == 0 ? 16'h2424 : $random(seed);
         outFrc = i == 0 ? 16'hE4E4 : $random(seed);
         outOperand <= $random(seed);
         apb(1, `TMCF_OFF_INFRC, {16'h0, inFrc});
         apb(1, `TMCF_OFF_OUTFRC, {16'h0, outFrc});
         frz = outOperand;
         apb(1, `TMCF_OFF_CTRL, {30'h0, i[0], 1'b1});
         if (i[0]) begin
            repeat (8) @(posedge clk);
            chk(testActive, 0);
            wantTrig <= 1;
         end
         waitAct(1);
         outOperand <= $random(seed);
         wantIn <= $random(seed);
         repeat (6) @(posedge clk);
         chk(inReport, expIn(inFrc, wantIn));
         chk(contactDrive, expOut(outFrc, outOperand, frz));
         repeat (12) if (testLed !== 1'b1) @(posedge clk);
         chk(testLed, 1);
         ce <= 0;
         repeat (3) @(posedge clk);
         ce <= 1;
         apb(0, `TMCF_OFF_STATUS, 0);
         chk(q[0], 1);
         apb(1, `TMCF_OFF_INFRC, 0);
         repeat (6) @(posedge clk);
         chk(inReport, wantIn);
         if (i[0]) wantTrig <= 0;
         else apb(1, `TMCF_OFF_CTRL, 0);
         waitAct(0);
         outOperand <= $random(seed);
         wantIn <= $random(seed);
         repeat (6) @(posedge clk);
         chk({inReport, contactDrive}, {wantIn, outOperand});
      end
      final_report;
   end
endmodule // test_tmcf_test_mode
